// >>> design/rmcv_cfg.svh
`ifndef RMCV_CFG_SVH
`define RMCV_CFG_SVH

// memory sizes of the reduced variant
`define RMCV_ROM_WORDS     512
`define RMCV_ROM_AW        9
`define RMCV_RAM_CELLS     32
`define RMCV_RAM_AW        5
`define RMCV_STACK_LEVELS  2

// single-word opcodes
`define RMCV_OP_CLRA       8'h01
`define RMCV_OP_LD         8'h02
`define RMCV_OP_X          8'h03
`define RMCV_OP_NOP        8'h04
`define RMCV_OP_RET        8'h05
`define RMCV_OP_READ_LATCHED_INPUTS_OP       8'h06
`define RMCV_OP_READ_GENERAL_INPUTS_OP       8'h07
`define RMCV_OP_SKT        8'h08
`define RMCV_OP_OUTPUT_LATCH_INDIRECT_LOAD_OP       8'h11
// first word of the two-word exchange, second word names the cell
`define RMCV_OP_XAD        8'h12
`define RMCV_XAD_OPERAND   8'h3f
`define RMCV_XAD_CELL      5'h1f

// opcode groups by upper bits
`define RMCV_GRP_LBI       2'b00
`define RMCV_GRP_JP        2'b10
`define RMCV_GRP_LEI       4'h4
`define RMCV_GRP_AISC      4'h5
`define RMCV_GRP_JSR       5'h0c

// field positions
`define RMCV_EN_IRQ_BIT    1
`define RMCV_READ_LATCHED_INPUTS_OP_CKO_BIT  2

// reset values
`define RMCV_PC_RST        9'h000
`define RMCV_ACC_RST       4'h0
`define RMCV_EN_RST        4'h0
`define RMCV_Q_RST         8'h00

`endif

// >>> design/rmcv_pkg.sv
package rmcv_pkg;
    `include "rmcv_cfg.svh"

    typedef logic [`RMCV_ROM_AW-1:0] rmcv_addr_t;

    typedef enum logic {
        PH_FETCH,
        PH_OPERAND
    } rmcv_phase_e;

    typedef struct packed {
        logic       we;
        rmcv_addr_t addr;
        logic [7:0] data;
    } rmcv_rom_wr_s;

    typedef struct packed {
        rmcv_addr_t pc;
        logic [3:0] acc;
        logic [1:0] br;
        logic [3:0] bd;
        logic [3:0] en;
        logic [7:0] q;
        logic       carry_skip;
    } rmcv_status_s;
endpackage

// >>> design/rmcv_save_stack.sv
`timescale 1ns/1ps
module rmcv_save_stack
    import rmcv_pkg::*;
#(
    parameter int LEVELS = `RMCV_STACK_LEVELS
) (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic                       ce,
    input  wire logic                       push,
    input  wire logic                       pop,
    input  wire rmcv_addr_t                 push_addr,
    output logic       [LEVELS-1:0][`RMCV_ROM_AW-1:0] levels
);
    logic [LEVELS-1:0][`RMCV_ROM_AW-1:0] lvl_r;
    logic [LEVELS-1:0][`RMCV_ROM_AW-1:0] lvl_nxt;

    // push and pop together keeps the top and still shifts the rest down,
    // so the deepest saved address is lost
    for (genvar i = 0; i < LEVELS; i++) begin : g_lvl
        always_comb begin
            lvl_nxt[i] = lvl_r[i];
            if (push) begin
                if (i == 0) begin
                    lvl_nxt[i] = pop ? lvl_r[0] : push_addr;
                end else begin
                    lvl_nxt[i] = lvl_r[i-1];
                end
            end else if (pop && (i < LEVELS - 1)) begin
                lvl_nxt[i] = lvl_r[i+1];
            end
        end

        always_ff @(posedge core_clk or negedge rst_b) begin
            if (!rst_b) begin
                lvl_r[i] <= `RMCV_PC_RST;
            end else if (ce) begin
                lvl_r[i] <= lvl_nxt[i];
            end
        end
    end

    assign levels = lvl_r;
endmodule

// >>> design/rmcv_core.sv
// Overview of operation
// RULE1 - the read-general-inputs opcode is not implemented on this variant
// RULE2 - latched-input read loads only the clock-out pin level, when it is an input
// RULE3 - setting the interrupt-enable bit has no effect; no interrupt is taken
// RULE4 - no parallel-bus handshake: no input strobes, no ready output
// RULE5 - program memory is 512 eight-bit words, eight pages numbered 0 to 7
// RULE6 - data memory is 32 nibbles: four registers of digits 9-15 and 0
// RULE7 - pointer-load-immediate takes only digits 9-15 or 0 and is one word
// RULE8 - direct accumulator exchange is valid only with register 3, digit 15
// RULE9 - two save registers form the stack: two nesting levels at most
// RULE10 - output-latch-indirect load pushes then pops, losing the deeper return address
// RULE11 - no divide-by-1024 time base and no skip on its overflow
// RULE12 - opcodes of omitted instructions execute as defined no-operations
`timescale 1ns/1ps
module rmcv_core
    import rmcv_pkg::*;
(
    input  wire logic          core_clk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    input  wire rmcv_rom_wr_s  rom_wr,
    input  wire logic          clock_out_pin,
    input  wire logic          cko_gp_en,
    output rmcv_status_s       status
);
    logic [7:0] rom [`RMCV_ROM_WORDS];  // see RULE5
    logic [3:0] ram [`RMCV_RAM_CELLS];

    rmcv_phase_e phase_r, phase_nxt;
    rmcv_addr_t  pc_r, pc_nxt;
    logic [3:0]  acc_r, acc_nxt;
    logic [1:0]  br_r, br_nxt;
    logic [3:0]  bd_r, bd_nxt;
    logic [3:0]  en_r, en_nxt;
    logic [7:0]  q_r, q_nxt;
    logic [7:0]  op_r, op_nxt;
    logic        skip_r, skip_nxt;
    logic        kill_r, kill_nxt;
    logic        cko_s1_r, cko_s2_r, cko_s3_r;
    logic        cko_lvl_r, cko_lvl_nxt;

    logic        ram_we;
    logic [`RMCV_RAM_AW-1:0] ram_waddr;
    logic [3:0]  ram_wdata;
    logic [`RMCV_RAM_AW-1:0] ram_idx;
    logic [3:0]  ram_rd;
    logic [7:0]  instr;
    logic [4:0]  sum;
    logic        lbi_ok;
    logic        push, pop;
    rmcv_addr_t  push_addr;
    logic [`RMCV_STACK_LEVELS-1:0][`RMCV_ROM_AW-1:0] stk;

    assign instr   = rom[pc_r];
    // digit 0 and 9-15 fold onto three bits, so 8 cells per register
    assign ram_idx = {br_r, bd_r[2:0]};  // see RULE6
    assign ram_rd  = ram[ram_idx];
    assign sum     = {1'b0, acc_r} + {1'b0, instr[3:0]};
    assign lbi_ok  = (instr[7:6] == `RMCV_GRP_LBI) &&
                     ((instr[3:0] == 4'h0) || (instr[3] && (instr[2:0] != 3'h0)));  // see RULE7

    rmcv_save_stack #(
        .LEVELS (`RMCV_STACK_LEVELS)
    ) u_stack (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .push      (push),
        .pop       (pop),
        .push_addr (push_addr),
        .levels    (stk)
    );

    // pin level is accepted only once the 2nd and 3rd stages agree
    assign cko_lvl_nxt = (cko_s2_r == cko_s3_r) ? cko_s3_r : cko_lvl_r;

    always_comb begin
        phase_nxt = phase_r;
        pc_nxt    = pc_r + 9'h001;
        acc_nxt   = acc_r;
        br_nxt    = br_r;
        bd_nxt    = bd_r;
        en_nxt    = en_r;
        q_nxt     = q_r;
        op_nxt    = op_r;
        skip_nxt  = skip_r;
        kill_nxt  = 1'b0;
        ram_we    = 1'b0;
        ram_waddr = ram_idx;
        ram_wdata = acc_r;
        push      = 1'b0;
        pop       = 1'b0;
        push_addr = pc_r + 9'h001;
        case (phase_r)
            PH_FETCH: begin
                op_nxt = instr;
                if (skip_r) begin
                    // a skipped two-word opcode must drop its operand too
                    skip_nxt = 1'b0;
                    if ((instr == `RMCV_OP_XAD) || (instr[7:3] == `RMCV_GRP_JSR)) begin
                        phase_nxt = PH_OPERAND;
                        kill_nxt  = 1'b1;
                    end
                end else begin
                    case (instr)
                        `RMCV_OP_CLRA: acc_nxt = 4'h0;
                        `RMCV_OP_LD:   acc_nxt = ram_rd;
                        `RMCV_OP_X: begin
                            acc_nxt = ram_rd;
                            ram_we  = 1'b1;
                        end
                        `RMCV_OP_RET: begin
                            pc_nxt = stk[0];
                            pop    = 1'b1;
                        end
                        `RMCV_OP_READ_LATCHED_INPUTS_OP: begin
                            // only the clock-out pin is latched-input data here
                            acc_nxt = 4'h0;  // see RULE2
                            acc_nxt[`RMCV_READ_LATCHED_INPUTS_OP_CKO_BIT] = cko_gp_en & cko_lvl_r;  // see RULE2
                        end
                        `RMCV_OP_OUTPUT_LATCH_INDIRECT_LOAD_OP: begin
                            // one stack level is borrowed for the table fetch
                            push  = 1'b1;  // see RULE10
                            pop   = 1'b1;  // see RULE10
                            q_nxt = rom[{pc_r[8], acc_r, ram_rd}];
                        end
                        `RMCV_OP_XAD: phase_nxt = PH_OPERAND;
                        // no general inputs, no time base: plain no-operations
                        `RMCV_OP_READ_GENERAL_INPUTS_OP, `RMCV_OP_SKT: ;  // see RULE1, see RULE11, see RULE12
                        default: begin
                            if (lbi_ok) begin
                                br_nxt = instr[5:4];
                                bd_nxt = instr[3:0];
                            end else if (instr[7:6] == `RMCV_GRP_JP) begin
                                pc_nxt = {pc_r[8:6], instr[5:0]};  // see RULE5
                            end else if (instr[7:4] == `RMCV_GRP_LEI) begin
                                // the interrupt enable bit is never stored
                                en_nxt = instr[3:0];
                                en_nxt[`RMCV_EN_IRQ_BIT] = 1'b0;  // see RULE3
                            end else if (instr[7:4] == `RMCV_GRP_AISC) begin
                                acc_nxt  = sum[3:0];
                                skip_nxt = sum[4];
                            end else if (instr[7:3] == `RMCV_GRP_JSR) begin
                                phase_nxt = PH_OPERAND;
                            end
                            // bus strobes and ready output are never decoded; any
                            // other opcode falls through unchanged
                            // see RULE4, see RULE12
                        end
                    endcase
                end
            end
            PH_OPERAND: begin
                phase_nxt = PH_FETCH;
                if (!kill_r) begin
                    if (op_r == `RMCV_OP_XAD) begin
                        if (instr == `RMCV_XAD_OPERAND) begin  // see RULE8
                            acc_nxt   = ram[`RMCV_XAD_CELL];
                            ram_we    = 1'b1;
                            ram_waddr = `RMCV_XAD_CELL;
                        end
                    end else begin
                        // a third nested call overwrites the deepest level
                        push   = 1'b1;  // see RULE9
                        pc_nxt = {op_r[2:0], instr[5:0]};
                    end
                end
            end
            default: phase_nxt = PH_FETCH;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_r   <= PH_FETCH;
            pc_r      <= `RMCV_PC_RST;
            acc_r     <= `RMCV_ACC_RST;
            br_r      <= 2'h0;
            bd_r      <= 4'h0;
            en_r      <= `RMCV_EN_RST;
            q_r       <= `RMCV_Q_RST;
            op_r      <= 8'h00;
            skip_r    <= 1'b0;
            kill_r    <= 1'b0;
            cko_s1_r  <= 1'b0;
            cko_s2_r  <= 1'b0;
            cko_s3_r  <= 1'b0;
            cko_lvl_r <= 1'b0;
        end else if (ce) begin
            phase_r   <= phase_nxt;
            pc_r      <= pc_nxt;
            acc_r     <= acc_nxt;
            br_r      <= br_nxt;
            bd_r      <= bd_nxt;
            en_r      <= en_nxt;
            q_r       <= q_nxt;
            op_r      <= op_nxt;
            skip_r    <= skip_nxt;
            kill_r    <= kill_nxt;
            cko_s1_r  <= clock_out_pin;
            cko_s2_r  <= cko_s1_r;
            cko_s3_r  <= cko_s2_r;
            cko_lvl_r <= cko_lvl_nxt;
        end
    end

    // memories carry no reset; the ROM is loaded through rom_wr before the core runs, the RAM is never loaded
    always_ff @(posedge core_clk) begin
        if (ce && rom_wr.we) begin
            rom[rom_wr.addr] <= rom_wr.data;
        end
        if (ce && ram_we) begin
            ram[ram_waddr] <= ram_wdata;
        end
    end

    assign status = '{pc: pc_r, acc: acc_r, br: br_r, bd: bd_r, en: en_r, q: q_r,
                      carry_skip: skip_r};

    logic exec;
    assign exec = ce && (phase_r == PH_FETCH) && !skip_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    a_read_general_inputs_op_no_effect: assert property (  // see RULE1
        exec && instr == `RMCV_OP_READ_GENERAL_INPUTS_OP |=> $stable(acc_r) && pc_r == $past(pc_r) + 9'h001)
        else $error("general input read changed state");
    a_read_latched_inputs_op_cko_only: assert property (  // see RULE2
        exec && instr == `RMCV_OP_READ_LATCHED_INPUTS_OP |=>
            acc_r == {1'b0, $past(cko_gp_en) & $past(cko_lvl_r), 2'b00})
        else $error("latched read loaded more than the clock-out level");
    a_irq_en_dead: assert property (  // see RULE3
        exec && instr[7:4] == `RMCV_GRP_LEI |=>
            en_r == ($past(instr[3:0]) & 4'b1101) ##1 !en_r[`RMCV_EN_IRQ_BIT] [*2])
        else $error("interrupt enable bit became set");
    a_jump_in_page: assert property (  // see RULE5
        exec && instr[7:6] == `RMCV_GRP_JP |=>
            pc_r == {$past(pc_r[8:6]), $past(instr[5:0])})
        else $error("page-local jump left its page");
    a_lbi_one_word: assert property (  // see RULE7
        exec && lbi_ok |=> phase_r == PH_FETCH && bd_r == $past(instr[3:0]) &&
            pc_r == $past(pc_r) + 9'h001)
        else $error("pointer load was not a single word");
    a_xad_bad_cell: assert property (  // see RULE8
        ce && phase_r == PH_OPERAND && !kill_r && op_r == `RMCV_OP_XAD &&
            instr != `RMCV_XAD_OPERAND |=> $stable(acc_r))
        else $error("exchange ran on a cell other than 3,15");
    a_call_saves_ret: assert property (  // see RULE9
        ce && phase_r == PH_OPERAND && !kill_r && op_r[7:3] == `RMCV_GRP_JSR |=>
            stk[0] == $past(pc_r) + 9'h001 && stk[1] == $past(stk[0]))
        else $error("call did not push its return address");
    a_output_latch_indirect_load_op_loses_deep: assert property (  // see RULE10
        exec && instr == `RMCV_OP_OUTPUT_LATCH_INDIRECT_LOAD_OP |=> stk[0] == $past(stk[0]) && stk[1] == $past(stk[0]))
        else $error("indirect latch load did not consume one level");
    a_skt_no_skip: assert property (  // see RULE11
        exec && instr == `RMCV_OP_SKT |=> !skip_r && phase_r == PH_FETCH)
        else $error("time base skip was taken");

    c_call_taken: cover property (ce && phase_r == PH_OPERAND && op_r[7:3] == `RMCV_GRP_JSR);
    c_return: cover property (exec && instr == `RMCV_OP_RET);
    c_output_latch_indirect_load_op: cover property (exec && instr == `RMCV_OP_OUTPUT_LATCH_INDIRECT_LOAD_OP);
    c_aisc_skip: cover property (exec && instr[7:4] == `RMCV_GRP_AISC && sum[4]);
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import rmcv_pkg::*;

    typedef logic [7:0] rmcv_tb_bytes_t [$];

    logic         core_clk;
    logic         rst_b;
    logic         ce;
    rmcv_rom_wr_s rom_wr;
    logic         clock_out_pin;
    logic         cko_gp_en;
    rmcv_status_s status;

    int           errors = 0;
    int           samples_checked = 0;
    int           cycles = 0;
    logic [31:0]  rnd = 32'd13;
    logic [7:0]   rom_m [512];
    logic [3:0]   ram_m [32];
    rmcv_status_s exp_s;
    rmcv_addr_t   stk0;
    rmcv_addr_t   stk1;

    rmcv_core rmcv_core_inst (
        .core_clk      (core_clk),
        .rst_b         (rst_b),
        .ce            (ce),
        .rom_wr        (rom_wr),
        .clock_out_pin (clock_out_pin),
        .cko_gp_en     (cko_gp_en),
        .status        (status)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] next_rnd();
        rnd = rnd ^ (rnd << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
        return rnd;
    endfunction

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // a hung core never reaches its closing loop, so cut the run short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("CHECK FAILED run length expected under 20000 seen 20000");
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic fill_rom();
        // 8'hff is unassigned, so stray fetches behave as nops
        for (int i = 0; i < 512; i++) begin
            rom_m[i] = 8'hff;
        end
    endtask

    task automatic place(input int a, input rmcv_tb_bytes_t b);
        foreach (b[i]) begin
            rom_m[a + i] = b[i];
        end
    endtask

    // instruction-level reference; stops at a jump to itself
    task automatic run_model(input logic ck);
        logic [7:0] w;
        logic [7:0] o;
        logic [4:0] ix;
        logic [4:0] s;
        logic [3:0] t;
        rmcv_addr_t p;
        exp_s = '0;
        stk0 = '0;
        stk1 = '0;
        for (int n = 0; n < 400; n++) begin
            p = exp_s.pc;
            w = rom_m[p];
            o = rom_m[p + 9'd1];
            ix = {exp_s.br, exp_s.bd[2:0]};
            if (exp_s.carry_skip) begin
                exp_s.carry_skip = 1'b0;
                exp_s.pc = p + ((w == 8'h12 || w[7:3] == 5'h0c) ? 9'd2 : 9'd1);
                continue;
            end
            if (w[7:6] == 2'b10 && w[5:0] == p[5:0]) break;
            exp_s.pc = p + 9'd1;
            case (w)
                8'h01: exp_s.acc = 4'h0;
                8'h02: exp_s.acc = ram_m[ix];
                8'h03: begin
                    t = exp_s.acc;
                    exp_s.acc = ram_m[ix];
                    ram_m[ix] = t;
                end
                8'h04, 8'h07, 8'h08: t = exp_s.acc;
                8'h05: begin
                    // the deeper level keeps its copy after a return
                    exp_s.pc = stk0;
                    stk0 = stk1;
                end
                8'h06: exp_s.acc = {1'b0, ck, 2'b00};
                8'h11: begin
                    exp_s.q = rom_m[{p[8], exp_s.acc, ram_m[ix]}];
                    stk1 = stk0;
                end
                8'h12: begin
                    exp_s.pc = p + 9'd2;
                    if (o == 8'h3f) begin
                        t = exp_s.acc;
                        exp_s.acc = ram_m[31];
                        ram_m[31] = t;
                    end
                end
                default: begin
                    if (w[7:6] == 2'b00 && (w[3:0] == 4'h0 || w[3:0] >= 4'h9)) begin
                        exp_s.br = w[5:4];
                        exp_s.bd = w[3:0];
                    end else if (w[7:6] == 2'b10) begin
                        exp_s.pc = {p[8:6], w[5:0]};
                    end else if (w[7:4] == 4'h4) begin
                        exp_s.en = w[3:0] & 4'hd;
                    end else if (w[7:4] == 4'h5) begin
                        s = {1'b0, exp_s.acc} + {1'b0, w[3:0]};
                        exp_s.acc = s[3:0];
                        exp_s.carry_skip = s[4];
                    end else if (w[7:3] == 5'h0c) begin
                        stk1 = stk0;
                        stk0 = p + 9'd2;
                        exp_s.pc = {w[2:0], o[5:0]};
                    end
                end
            endcase
        end
    endtask

    task automatic run_test(input string nm, input logic gp, input logic pin);
        @(posedge core_clk);
        rst_b <= 1'b0;
        ce <= 1'b1;
        cko_gp_en <= gp;
        clock_out_pin <= pin;
        for (int n = 0; n < 512; n++) begin
            @(posedge core_clk);
            rom_wr <= '{we: 1'b1, addr: rmcv_addr_t'(n), data: rom_m[n]};
        end
        @(posedge core_clk);
        rom_wr.we <= 1'b0;
        @(posedge core_clk);
        chk({nm, " reset"}, 34'h0, status);
        rst_b <= 1'b1;
        // random stalls: a frozen core must pick up exactly where it left off
        for (int n = 0; n < 160; n++) begin
            @(posedge core_clk);
            ce <= (next_rnd() % 4) != 0;
        end
        @(posedge core_clk);
        run_model(gp & pin);
        chk(nm, exp_s, status);
        $display("test %s done", nm);
    endtask

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        rom_wr = '0;
        clock_out_pin = 1'b0;
        cko_gp_en = 1'b0;
        repeat (3) @(posedge core_clk);
        for (int k = 0; k < 4; k++) begin
            fill_rom();
            place(0, '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h06, 8'h53,
                       8'h07, 8'h08, 8'h4f, 8'hff, 8'h70, 8'h68, 8'h8e});
            run_test("latched input and omitted ops", k[1], k[0]);
        end
        fill_rom();
        place(0, '{8'h3f, 8'h5a, 8'h03, 8'h01, 8'h02, 8'h29, 8'h55, 8'h03,
                   8'h01, 8'h5c, 8'h12, 8'h3f, 8'h12, 8'h3e, 8'h23, 8'h5f,
                   8'h01, 8'h02, 8'h5f, 8'h12, 8'h3f, 8'h3f, 8'h02, 8'h10, 8'h98});
        run_test("pointer exchange and skip", 1'b0, 1'b0);
        for (int k = 0; k < 2; k++) begin
            fill_rom();
            place(0, '{8'h3f, 8'h5a, 8'h03, 8'h01, 8'h53, 8'h60, 8'h10, 8'h87});
            place(9'h010, '{8'h67, 8'h00, 8'h58, 8'h05, 8'h94});
            place(9'h1c0, '{(k != 0) ? 8'h11 : 8'h04, 8'h05});
            place(9'h13a, '{8'ha5});
            place(9'h03a, '{8'h5a});
            run_test("two level nesting", 1'b0, 1'b0);
        end
        wrap_up();
    end
endmodule
